// ### ptd_pkg.sv
package ptd_pkg;

  // ****************************************
  // Opcode bytes
  // ****************************************
  // First byte of low-nibble loads
  localparam logic [7:0] PTD_FIRST_LOAD_LOW = 8'h6A;
  // First byte of mid/high/stack loads, also the lone no-operation
  localparam logic [7:0] PTD_FIRST_LOAD_UPPER = 8'h56;
  localparam logic [7:0] PTD_NO_OPERATION = 8'h56;
  // First byte of every store
  localparam logic [7:0] PTD_FIRST_STORE = 8'h69;
  // High nibble of every valid second byte
  localparam logic [3:0] PTD_SEL_PREFIX = 4'hF;

  // ****************************************
  // Second-byte selectors (low nibble)
  // ****************************************
  localparam logic [3:0] PTD_SEL_PTR_LOW = 4'hC;
  localparam logic [3:0] PTD_SEL_PTR_MID = 4'hD;
  localparam logic [3:0] PTD_SEL_PTR_HIGH = 4'hE;
  localparam logic [3:0] PTD_SEL_STACK = 4'hF;
  localparam logic [3:0] PTD_SEL_T1_LOW = 4'h4;
  localparam logic [3:0] PTD_SEL_T1_MID = 4'h5;
  localparam logic [3:0] PTD_SEL_T1_HIGH = 4'h6;
  localparam logic [3:0] PTD_SEL_T2_LOW = 4'h8;
  localparam logic [3:0] PTD_SEL_T2_MID = 4'h9;
  localparam logic [3:0] PTD_SEL_T2_HIGH = 4'hA;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int PTD_NIBBLES = 3;
  localparam logic [1:0] PTD_NIB_LOW = 2'h0;
  localparam logic [1:0] PTD_NIB_MID = 2'h1;
  localparam logic [1:0] PTD_NIB_HIGH = 2'h2;
  // Value the status flag takes on every transfer
  localparam logic PTD_STATUS_ON_XFER = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {
    PTD_PH_FIRST,
    PTD_PH_SECOND
  } ptd_phase_t;

  typedef enum logic [1:0] {
    PTD_TGT_PTR,
    PTD_TGT_T1,
    PTD_TGT_T2,
    PTD_TGT_STACK
  } ptd_target_t;

  typedef struct packed {
    ptd_phase_t phase;
    logic [7:0] first;
    logic acc_we;
    logic [3:0] acc_data;
    logic zf_we;
    logic zf;
    logic sf_we;
    logic sf;
    logic [2:0] ptr_we;
    logic [2:0] tmr1_we;
    logic [2:0] tmr2_we;
    logic sp_we;
    logic [3:0] wr_data;
    logic nop_done;
    logic illegal;
    logic foreign;
  } ptd_state_t;

  localparam ptd_state_t PTD_STATE_RESET = '0;

endpackage : ptd_pkg

// ### ptd_nibble_pick.sv
`timescale 1ns/100ps
module ptd_nibble_pick (
  // Source word and nibble index
  input wire logic [11:0] word_i,
  input wire logic [1:0] idx_i,
  // Selected nibble
  output logic [3:0] nib_o
);
  import ptd_pkg::*;

  logic [3:0] masked [PTD_NIBBLES];

  // ****************************************
  // AND-OR pick, one term per nibble
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < PTD_NIBBLES; g++) begin : g_nib
      assign masked[g] = (idx_i == 2'(g)) ? word_i[4*g +: 4] : 4'h0;
    end
  endgenerate

  // Index 3 is never requested, so it reads as zero
  assign nib_o = masked[0] | masked[1] | masked[2];

endmodule : ptd_nibble_pick

// ### ptd_decode.sv
// Notes on behaviour
// - Low pointer load copies pointer bits 3:0 to acc, sets zero; store writes them.
// - Middle pointer load/store moves bits 7:4; store leaves carry and zero alone.
// - High pointer load/store moves bits 11:8; every transfer sets the status flag.
// - Low timer nibble: selector 4 picks timer one, 8 timer two; 6A loads, 69 stores.
// - Middle timer nibble: 56 loads, 69 stores, selectors 5 or 9.
// - High timer nibble: selectors 6 or A; loads set zero, stores leave it.
// - Stack pointer load sets zero flag; store leaves it; two bytes, status set.
`timescale 1ns/100ps
module ptd_decode (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Opcode byte stream from fetch
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // Datapath sources
  input wire logic [3:0] acc_i,
  input wire logic [11:0] data_pointer_i,
  input wire logic [3:0] stack_pointer_i,
  input wire logic [11:0] timer1_i,
  input wire logic [11:0] timer2_i,
  // Accumulator and flags
  output logic acc_we_o,
  output logic [3:0] acc_data_o,
  output logic zero_flag_we_o,
  output logic zero_flag_o,
  output logic status_flag_we_o,
  output logic status_flag_o,
  // Nibble write enables and data
  output logic [2:0] ptr_nib_we_o,
  output logic [2:0] timer1_nib_we_o,
  output logic [2:0] timer2_nib_we_o,
  output logic stack_ptr_we_o,
  output logic [3:0] wr_data_o,
  // Sequence status
  output logic nop_done_o,
  output logic illegal_o,
  output logic foreign_o
);
  import ptd_pkg::*;

  ptd_state_t st_reg;
  ptd_state_t st_next;
  ptd_target_t tgt;
  logic [1:0] nib_idx;
  logic sel_ok;
  logic [7:0] load_first;
  logic [11:0] src_word;
  logic [3:0] src_nib;
  logic [3:0] load_val;
  logic is_first_code;

  // ****************************************
  // Second-byte selector decode
  // ****************************************
  // Target, nibble index and expected load first byte from the selector
  always_comb begin
    tgt = PTD_TGT_PTR;
    nib_idx = PTD_NIB_LOW;
    sel_ok = (byte_i[7:4] == PTD_SEL_PREFIX);
    unique case (byte_i[3:0])
      PTD_SEL_PTR_LOW: nib_idx = PTD_NIB_LOW;
      PTD_SEL_PTR_MID: nib_idx = PTD_NIB_MID;
      PTD_SEL_PTR_HIGH: nib_idx = PTD_NIB_HIGH;
      PTD_SEL_STACK: tgt = PTD_TGT_STACK;
      PTD_SEL_T1_LOW: tgt = PTD_TGT_T1;
      PTD_SEL_T1_MID: begin
        tgt = PTD_TGT_T1;
        nib_idx = PTD_NIB_MID;
      end
      PTD_SEL_T1_HIGH: begin
        tgt = PTD_TGT_T1;
        nib_idx = PTD_NIB_HIGH;
      end
      PTD_SEL_T2_LOW: tgt = PTD_TGT_T2;
      PTD_SEL_T2_MID: begin
        tgt = PTD_TGT_T2;
        nib_idx = PTD_NIB_MID;
      end
      PTD_SEL_T2_HIGH: begin
        tgt = PTD_TGT_T2;
        nib_idx = PTD_NIB_HIGH;
      end
      default: sel_ok = 1'b0;
    endcase
    // Low-nibble loads carry a different first byte than the rest
    load_first = (nib_idx == PTD_NIB_LOW && tgt != PTD_TGT_STACK) ? PTD_FIRST_LOAD_LOW : PTD_FIRST_LOAD_UPPER;
  end

  // Source word for loads
  always_comb begin
    unique case (tgt)
      PTD_TGT_T1: src_word = timer1_i;
      PTD_TGT_T2: src_word = timer2_i;
      default: src_word = data_pointer_i;
    endcase
  end

  ptd_nibble_pick u_pick (
    .word_i(src_word),
    .idx_i(nib_idx),
    .nib_o(src_nib)
  );

  assign load_val = (tgt == PTD_TGT_STACK) ? stack_pointer_i : src_nib;
  assign is_first_code = (byte_i == PTD_FIRST_LOAD_LOW) || (byte_i == PTD_FIRST_LOAD_UPPER)
    || (byte_i == PTD_FIRST_STORE);

  // ****************************************
  // Sequencer
  // ****************************************
  // Pulses last one cycle; carry is never touched by this block
  always_comb begin
    logic redecode;
    redecode = 1'b0;
    st_next = st_reg;
    st_next.acc_we = 1'b0;
    st_next.zf_we = 1'b0;
    st_next.sf_we = 1'b0;
    st_next.ptr_we = 3'h0;
    st_next.tmr1_we = 3'h0;
    st_next.tmr2_we = 3'h0;
    st_next.sp_we = 1'b0;
    st_next.nop_done = 1'b0;
    st_next.illegal = 1'b0;
    st_next.foreign = 1'b0;
    if (byte_valid_i && st_reg.phase == PTD_PH_SECOND) begin
      st_next.phase = PTD_PH_FIRST;
      if (sel_ok && st_reg.first == load_first) begin
        st_next.acc_we = 1'b1;
        st_next.acc_data = load_val;
        st_next.zf_we = 1'b1;
        st_next.zf = (load_val == 4'h0);
        st_next.sf_we = 1'b1;
        st_next.sf = PTD_STATUS_ON_XFER;
      end else if (sel_ok && st_reg.first == PTD_FIRST_STORE) begin
        st_next.wr_data = acc_i;
        st_next.sf_we = 1'b1;
        st_next.sf = PTD_STATUS_ON_XFER;
        unique case (tgt)
          PTD_TGT_PTR: st_next.ptr_we[nib_idx] = 1'b1;
          PTD_TGT_T1: st_next.tmr1_we[nib_idx] = 1'b1;
          PTD_TGT_T2: st_next.tmr2_we[nib_idx] = 1'b1;
          PTD_TGT_STACK: st_next.sp_we = 1'b1;
        endcase
      end else if (st_reg.first == PTD_NO_OPERATION) begin
        // Lone no-operation, this byte starts anew
        st_next.nop_done = 1'b1;
        redecode = 1'b1;
      end else begin
        st_next.illegal = 1'b1;
      end
    end
    if (byte_valid_i && (st_reg.phase == PTD_PH_FIRST || redecode)) begin
      if (is_first_code) begin
        st_next.phase = PTD_PH_SECOND;
        st_next.first = byte_i;
      end else begin
        st_next.foreign = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= PTD_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign acc_we_o = st_reg.acc_we;
  assign acc_data_o = st_reg.acc_data;
  assign zero_flag_we_o = st_reg.zf_we;
  assign zero_flag_o = st_reg.zf;
  assign status_flag_we_o = st_reg.sf_we;
  assign status_flag_o = st_reg.sf;
  assign ptr_nib_we_o = st_reg.ptr_we;
  assign timer1_nib_we_o = st_reg.tmr1_we;
  assign timer2_nib_we_o = st_reg.tmr2_we;
  assign stack_ptr_we_o = st_reg.sp_we;
  assign wr_data_o = st_reg.wr_data;
  assign nop_done_o = st_reg.nop_done;
  assign illegal_o = st_reg.illegal;
  assign foreign_o = st_reg.foreign;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  ptr_low_load_a:
    assert property ((byte_valid_i && byte_i == PTD_FIRST_LOAD_LOW && st_reg.phase == PTD_PH_FIRST)
      ##1 (byte_valid_i && byte_i == {PTD_SEL_PREFIX, PTD_SEL_PTR_LOW})
      |=> acc_we_o && acc_data_o == $past(data_pointer_i[3:0]) && zero_flag_we_o)
    else $error("low pointer load did not reach acc");

  ptr_mid_store_a:
    assert property ((st_reg.phase == PTD_PH_SECOND && st_reg.first == PTD_FIRST_STORE && byte_valid_i
      && byte_i == {PTD_SEL_PREFIX, PTD_SEL_PTR_MID})
      |=> ptr_nib_we_o == 3'h2 && wr_data_o == $past(acc_i) && !zero_flag_we_o && !acc_we_o)
    else $error("middle pointer store wrong");

  xfer_status_a:
    assert property ((|ptr_nib_we_o || |timer1_nib_we_o || |timer2_nib_we_o || stack_ptr_we_o || acc_we_o)
      |-> status_flag_we_o && status_flag_o)
    else $error("transfer without status flag");

  timer_low_sel_a:
    assert property ((st_reg.phase == PTD_PH_SECOND && st_reg.first == PTD_FIRST_STORE && byte_valid_i
      && byte_i == {PTD_SEL_PREFIX, PTD_SEL_T2_LOW}) |=> timer2_nib_we_o == 3'h1 && timer1_nib_we_o == 3'h0)
    else $error("low timer selector misrouted");

  timer_mid_load_a:
    assert property ((st_reg.phase == PTD_PH_SECOND && st_reg.first == PTD_FIRST_LOAD_UPPER && byte_valid_i
      && byte_i == {PTD_SEL_PREFIX, PTD_SEL_T1_MID}) |=> acc_we_o && acc_data_o == $past(timer1_i[7:4]))
    else $error("middle timer load wrong");

  timer_high_zero_a:
    assert property ((st_reg.phase == PTD_PH_SECOND && st_reg.first == PTD_FIRST_LOAD_UPPER && byte_valid_i
      && byte_i == {PTD_SEL_PREFIX, PTD_SEL_T2_HIGH})
      |=> zero_flag_we_o && zero_flag_o == ($past(timer2_i[11:8]) == 4'h0))
    else $error("high timer load zero flag wrong");

  stack_load_a:
    assert property ((st_reg.phase == PTD_PH_SECOND && st_reg.first == PTD_FIRST_LOAD_UPPER && byte_valid_i
      && byte_i == {PTD_SEL_PREFIX, PTD_SEL_STACK}) |=> acc_we_o && acc_data_o == $past(stack_pointer_i))
    else $error("stack pointer load wrong");

  lone_nop_a:
    assert property ((st_reg.phase == PTD_PH_SECOND && st_reg.first == PTD_NO_OPERATION && byte_valid_i
      && !(byte_i[7:4] == PTD_SEL_PREFIX && byte_i[3:0] inside {4'h5, 4'h6, 4'h9, 4'hA, 4'hD, 4'hE, 4'hF}))
      |=> nop_done_o && !zero_flag_we_o && !status_flag_we_o && !acc_we_o)
    else $error("lone no-operation mishandled");

  one_action_a:
    assert property (nop_done_o |-> !illegal_o && (st_reg.phase == PTD_PH_SECOND || foreign_o))
    else $error("no-operation byte not redecoded");

endmodule : ptd_decode

// ### ptd_dpath_model.sv
`timescale 1ns/100ps
module ptd_dpath_model #(
  parameter logic [11:0] DP_INIT = 12'h3A0,
  parameter logic [11:0] T1_INIT = 12'h5C7,
  parameter logic [11:0] T2_INIT = 12'h91E,
  parameter logic [3:0] SP_INIT = 4'h6
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Decoder commands
  input wire logic acc_we_i,
  input wire logic [3:0] acc_data_i,
  input wire logic [2:0] ptr_we_i,
  input wire logic [2:0] t1_we_i,
  input wire logic [2:0] t2_we_i,
  input wire logic sp_we_i,
  input wire logic [3:0] wr_data_i,
  // Register contents
  output logic [3:0] acc_o,
  output logic [11:0] dp_o,
  output logic [11:0] t1_o,
  output logic [11:0] t2_o,
  output logic [3:0] sp_o
);
  // Datapath registers; a write lands on the edge after the request
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_o <= 4'h0;
      dp_o <= DP_INIT;
      t1_o <= T1_INIT;
      t2_o <= T2_INIT;
      sp_o <= SP_INIT;
    end else begin
      if (acc_we_i) begin
        acc_o <= acc_data_i;
      end
      if (sp_we_i) begin
        sp_o <= wr_data_i;
      end
      // One nibble per enable bit, low nibble first
      for (int n = 0; n < 3; n++) begin
        if (ptr_we_i[n]) dp_o[n*4 +: 4] <= wr_data_i;
        if (t1_we_i[n]) t1_o[n*4 +: 4] <= wr_data_i;
        if (t2_we_i[n]) t2_o[n*4 +: 4] <= wr_data_i;
      end
    end
  end
endmodule : ptd_dpath_model

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ptd_pkg::*;
  localparam logic [11:0] DP0 = 12'h3A0;
  localparam logic [11:0] T10 = 12'h5C7;
  localparam logic [11:0] T20 = 12'h91E;
  localparam logic [3:0] SP0 = 4'h6;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic byte_valid_i = 1'b0;
  logic [7:0] byte_i = 8'h00;
  logic [3:0] acc, sp, acc_data, wr_data;
  logic [11:0] dp, t1, t2;
  logic acc_we, zf_we, zf, sf_we, sf, sp_we, nop_done, illegal, foreign;
  logic [2:0] ptr_we, t1_we, t2_we;
  int num_errors = 0;
  int comparisons = 0;

  ptd_decode i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .acc_i(acc), .data_pointer_i(dp), .stack_pointer_i(sp), .timer1_i(t1),
    .timer2_i(t2), .acc_we_o(acc_we), .acc_data_o(acc_data), .zero_flag_we_o(zf_we),
    .zero_flag_o(zf), .status_flag_we_o(sf_we), .status_flag_o(sf), .ptr_nib_we_o(ptr_we),
    .timer1_nib_we_o(t1_we), .timer2_nib_we_o(t2_we), .stack_ptr_we_o(sp_we),
    .wr_data_o(wr_data), .nop_done_o(nop_done), .illegal_o(illegal), .foreign_o(foreign));

  ptd_dpath_model #(.DP_INIT(DP0), .T1_INIT(T10), .T2_INIT(T20), .SP_INIT(SP0)) i_dpath (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .acc_we_i(acc_we), .acc_data_i(acc_data),
    .ptr_we_i(ptr_we), .t1_we_i(t1_we), .t2_we_i(t2_we), .sp_we_i(sp_we),
    .wr_data_i(wr_data), .acc_o(acc), .dp_o(dp), .t1_o(t1), .t2_o(t2), .sp_o(sp));

  // Clock at 40 MHz
  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One opcode byte, taken at the next edge
  task automatic put(input logic [7:0] b);
    @(posedge ref_clk_i);
    byte_valid_i <= 1'b1;
    byte_i <= b;
  endtask : put

  // Stop the stream and let the last edge's outputs settle
  task automatic idle();
    @(posedge ref_clk_i);
    byte_valid_i <= 1'b0;
    #1;
  endtask : idle

  // Each load followed by the matching store, back to back
  task automatic test_transfers();
    logic [3:0] sel[10] = '{4'hC, 4'hD, 4'hE, 4'hF, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA};
    logic [3:0] val[10] = '{DP0[3:0], DP0[7:4], DP0[11:8], SP0, T10[3:0], T10[7:4],
      T10[11:8], T20[3:0], T20[7:4], T20[11:8]};
    int bitpos[10] = '{6, 7, 8, 9, 3, 4, 5, 0, 1, 2};
    logic [7:0] first;
    for (int i = 0; i < 10; i++) begin
      first = (sel[i] inside {4'hC, 4'h4, 4'h8}) ? 8'h6A : 8'h56;
      put(first);
      put({4'hF, sel[i]});
      put(8'h69);
      // Load pulses were launched at this edge; let them settle first
      #1;
      check("acc_we", 12'h1, {11'h0, acc_we});
      check("acc_data", {8'h0, val[i]}, {8'h0, acc_data});
      check("zf", {10'h0, 1'b1, val[i] == 4'h0}, {10'h0, zf_we, zf});
      check("sf", 12'h3, {10'h0, sf_we, sf});
      check("ld_we", 12'h0, {2'h0, sp_we, ptr_we, t1_we, t2_we});
      put({4'hF, sel[i]});
      idle();
      check("st_we", 12'h1 << bitpos[i], {2'h0, sp_we, ptr_we, t1_we, t2_we});
      check("wr_data", {8'h0, val[i]}, {8'h0, wr_data});
      // Store raises only the status write: no acc, no zero flag
      check("st_flags", 12'h1, {9'h0, acc_we, zf_we, sf_we});
      check("st_sf", 12'h1, {11'h0, sf});
      @(posedge ref_clk_i);
      #1;
      check("pulse_end", 12'h0, {1'h0, sf_we, sp_we, ptr_we, t1_we, t2_we});
    end
  endtask : test_transfers

  // Lone no-operation ended by a store's first byte
  task automatic test_nop();
    put(PTD_NO_OPERATION);
    put(PTD_FIRST_STORE);
    put(8'hFD);
    #1;
    check("nop_done", 12'h1, {11'h0, nop_done});
    check("nop_flags", 12'h0, {9'h0, acc_we, zf_we, sf_we});
    idle();
    check("after_nop", 12'h2, {9'h0, ptr_we});
    check("nop_once", 12'h0, {11'h0, nop_done});
  endtask : test_nop

  // Bad pair and a byte of another decoder
  task automatic test_bad_bytes();
    put(PTD_FIRST_LOAD_LOW);
    put(8'hF5);
    put(8'h12);
    #1;
    check("illegal", 12'h1, {11'h0, illegal});
    check("bad_we", 12'h0, {acc_we, sf_we, sp_we, ptr_we, t1_we, t2_we});
    idle();
    check("foreign", 12'h1, {11'h0, foreign});
  endtask : test_bad_bytes

  task automatic wrap_up();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    #1;
    check("reset_sf", 12'h0, {10'h0, sf_we, sf});
    test_transfers();
    test_nop();
    test_bad_bytes();
    wrap_up();
  end

  // Watchdog well beyond the roughly 75 cycles the tests need
  initial begin
    #50000;
    num_errors++;
    wrap_up();
  end
endmodule : tb_top
